// >>> rtl/msp_consts.vh
// constants for the module swap policy check block
// Operation
// RULE_01: power module replaced while powered: power swap
// RULE_02: new board or other module: board swap; code: other module fitted while powered on a known board is a power swap
// RULE_03: module exchanged while unpowered: board swap
// RULE_04: same module or board reinserted: no swap
// RULE_05: detect by comparing module serial number
// RULE_06: rejected swap leaves stored serial unchanged
// RULE_07: units digit governs power module swap
// RULE_08: tens digit governs control board swap
// RULE_09: rejection raises the single swap fault
// RULE_10: board swap uses new board's policy
// RULE_11: weaker module lowers current limit settings; code: not when a required card was loaded in the same run-up
// RULE_12: limit reduction regardless of policy, persists
// RULE_13: stronger module leaves current limit unchanged
// RULE_14: board swap with readable card loads card
// RULE_15: start only if slot, safety, card match
// RULE_16: mismatched card still loads, then error, no start
// RULE_17: no card: check stored slot against controller
// RULE_18: card required: card low rating data loaded
// RULE_19: card copy waits for module link and supply
`ifndef MSP_CONSTS_VH
`define MSP_CONSTS_VH
`define MSP_POL_REJECT   2'h0
`define MSP_POL_ORDER    2'h1
`define MSP_POL_STACK    2'h2
`define MSP_POL_ACCEPT   2'h3
`define MSP_CLS_NONE     2'h0
`define MSP_CLS_POWER    2'h1
`define MSP_CLS_BOARD    2'h2
`define MSP_REG_STATUS   4'h0
`define MSP_REG_MASK     4'h1
`define MSP_REG_POLICY   4'h2
`define MSP_REG_LIMIT    4'h3
`define MSP_REG_SERIAL   4'h4
`define MSP_REG_RESULT   4'h5
`define MSP_REG_SLOT     4'h6
`define MSP_REG_CTRL     4'h7
`define MSP_SLOT_SAFE_BIT 8
`define MSP_SLOT_CREQ_BIT 9
`define MSP_EV_DONE      0
`define MSP_EV_FAULT     1
`define MSP_EV_LIMIT     2
`define MSP_EV_START_ERR 3
`define MSP_NEV          4
`define MSP_COPY_TIME_NS 1000
`define MSP_CLK_PERIOD_NS 4
`define MSP_COPY_CYC     ((`MSP_COPY_TIME_NS + `MSP_CLK_PERIOD_NS - 1) / `MSP_CLK_PERIOD_NS)
`define MSP_LIMIT_RST    16'hffff
`endif

// >>> rtl/msp_policy_eval.v
// policy digit evaluation for one swap class
`timescale 1ns/1ps
`default_nettype none
`include "msp_consts.vh"
module msp_policy_eval (
  input  wire [1:0] digit,
  input  wire       order_same,
  input  wire       stack_same,
  output reg        accept
);
  // see RULE_07 see RULE_08
  always @* begin
    case (digit)
      `MSP_POL_REJECT: accept = 1'b0;
      `MSP_POL_ORDER:  accept = order_same;
      `MSP_POL_STACK:  accept = stack_same;
      default:         accept = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// >>> rtl/msp_swap_check.v
// run-up swap classification, policy check and card load sequencing
`timescale 1ns/1ps
`default_nettype none
`include "msp_consts.vh"
module msp_swap_check #(
  parameter SW   = 32,
  parameter OW   = 16,
  parameter LW   = 16,
  parameter SLW  = 8,
  parameter COPY = `MSP_COPY_CYC
) (
  input  wire           SYS_CLK,
  input  wire           NRST,
  input  wire           RUNUP_REQ,
  input  wire           BOARD_NEW,
  input  wire           BOARD_WAS_OFF,
  input  wire           MODULE_LINK,
  input  wire           SUPPLY_OK,
  input  wire [SW-1:0]  MODULE_SERIAL,
  input  wire [OW-1:0]  MODULE_ORDER,
  input  wire [OW-1:0]  MODULE_STACK,
  input  wire [LW-1:0]  MODULE_LIMIT,
  input  wire           CARD_PRESENT,
  input  wire           CARD_READABLE,
  input  wire [LW-1:0]  CARD_LIMIT,
  input  wire [SLW-1:0] CARD_SLOT,
  input  wire           CARD_SAFETY,
  input  wire           CARD_REQUIRED,
  input  wire [7:0]     CARD_POLICY,
  input  wire [SLW-1:0] CTRL_SLOT,
  input  wire           CTRL_SAFETY,
  input  wire           CTRL_CARD_REQ,
  input  wire [3:0]     REG_ADDR,
  input  wire [31:0]    REG_WDATA,
  input  wire           REG_WR,
  input  wire           REG_RD,
  output reg  [31:0]    REG_RDATA,
  output reg            IRQ,
  output reg            SWAP_FAULT,
  output reg            START_OK,
  output reg            CARD_COPY_BUSY,
  output reg  [1:0]     SWAP_CLASS
);
  // ==========================================================
  // shared decodes
  function wr_hit;
    input [3:0] addr;
    input [3:0] target;
    input       wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  function swap_reject;
    input [1:0] cls_in;
    input       power_ok;
    input       board_ok;
    begin
      swap_reject = ((cls_in == `MSP_CLS_POWER) && !power_ok) ||
                    ((cls_in == `MSP_CLS_BOARD) && !board_ok);
    end
  endfunction

  // a limit pinned by a required card is never lowered
  function limit_lower;
    input [LW-1:0] module_limit;
    input [LW-1:0] limit_now;
    input          card_pinned;
    begin
      limit_lower = (module_limit < limit_now) && !card_pinned;
    end
  endfunction

  // ==========================================================
  // reset release and pin synchronisers
  reg [1:0] rst_sync_q;
  wire      rst_n = rst_sync_q[1];
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  localparam NPIN = 7;
  wire [NPIN-1:0] pin_raw = {RUNUP_REQ, BOARD_NEW, BOARD_WAS_OFF, MODULE_LINK, SUPPLY_OK,
                             CARD_PRESENT, CARD_READABLE};
  reg  [NPIN-1:0] pin_s1_q;
  reg  [NPIN-1:0] pin_s2_q;
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= {NPIN{1'b0}};
      pin_s2_q <= {NPIN{1'b0}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  wire runup_s   = pin_s2_q[6];
  wire new_s     = pin_s2_q[5];
  wire wasoff_s  = pin_s2_q[4];
  wire link_s    = pin_s2_q[3];
  wire supply_s  = pin_s2_q[2];
  wire card_ok_s = pin_s2_q[1] & pin_s2_q[0];

  // controller settings, static but from another domain
  localparam NCTL = SLW + 2;
  reg  [NCTL-1:0] ctrl_s1_q;
  reg  [NCTL-1:0] ctrl_s2_q;
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_s1_q <= {NCTL{1'b0}};
      ctrl_s2_q <= {NCTL{1'b0}};
    end else begin
      ctrl_s1_q <= {CTRL_CARD_REQ, CTRL_SAFETY, CTRL_SLOT};
      ctrl_s2_q <= ctrl_s1_q;
    end
  end
  wire [SLW-1:0] ctrl_slot_s = ctrl_s2_q[SLW-1:0];
  wire           ctrl_safe_s = ctrl_s2_q[SLW];
  wire           ctrl_creq_s = ctrl_s2_q[SLW+1];

  reg runup_d1_q;
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      runup_d1_q <= 1'b0;
    end else begin
      runup_d1_q <= runup_s;
    end
  end
  wire runup_go = runup_s & ~runup_d1_q;

  // ==========================================================
  // stored state
  reg [SW-1:0]  serial_q;
  reg [OW-1:0]  order_q;
  reg [OW-1:0]  stack_q;
  reg [LW-1:0]  rated_q;
  reg [LW-1:0]  limit_q;
  reg [7:0]     policy_q;
  reg [SLW-1:0] slot_q;
  reg           safety_q;
  reg           card_req_q;
  reg           valid_q;
  reg [`MSP_NEV-1:0] status_q;
  reg [`MSP_NEV-1:0] mask_q;
  reg [`MSP_NEV-1:0] ev;

  localparam ST_IDLE  = 5'h01;
  localparam ST_WAIT  = 5'h02;
  localparam ST_COPY  = 5'h04;
  localparam ST_EVAL  = 5'h08;
  localparam ST_START = 5'h10;
  reg [4:0]  state_q;
  reg [15:0] copy_cnt_q;
  reg        card_used_q;
  reg        card_slot_bad_q;

  // ==========================================================
  // classification
  wire serial_same = valid_q && (MODULE_SERIAL == serial_q);
  wire order_same  = (MODULE_ORDER == order_q);
  wire stack_same  = (MODULE_STACK == stack_q);
  reg  [1:0] cls;
  always @*begin
    cls = `MSP_CLS_NONE;
    if (new_s || !valid_q) begin
      cls = `MSP_CLS_BOARD;                   // see RULE_02
    end else if (!serial_same) begin        // see RULE_05
      if (wasoff_s) begin
        cls = `MSP_CLS_BOARD;                 // see RULE_03
      end else begin
        cls = `MSP_CLS_POWER;                 // see RULE_01
      end
    end
    // same serial on known board: reinsert only, see RULE_04
  end

  // ==========================================================
  // policy check
  wire [7:0] pol_use = (state_q == ST_EVAL && cls == `MSP_CLS_BOARD && card_used_q)
                       ? CARD_POLICY : policy_q;   // see RULE_10
  wire acc_power;
  wire acc_board;
  msp_policy_eval u_eval_power (
    .digit      (pol_use[1:0]),
    .order_same (order_same),
    .stack_same (stack_same),
    .accept     (acc_power)
  );
  msp_policy_eval u_eval_board (
    .digit      (pol_use[5:4]),
    .order_same (order_same),
    .stack_same (stack_same),
    .accept     (acc_board)
  );
  wire reject_now = swap_reject(cls, acc_power, acc_board);   // see RULE_09
  wire lower_now  = limit_lower(MODULE_LIMIT, limit_q, card_used_q && card_req_q);

  // ==========================================================
  // run-up sequencer
  wire [SLW-1:0] slot_cmp  = slot_q;
  wire           start_ok  = (ctrl_slot_s == slot_cmp) && (ctrl_safe_s == safety_q) &&
                             (ctrl_creq_s == card_req_q);   // see RULE_15 see RULE_17

  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q         <= ST_IDLE;
      copy_cnt_q      <= 16'h0000;
      card_used_q     <= 1'b0;
      card_slot_bad_q <= 1'b0;
      serial_q        <= {SW{1'b0}};
      order_q         <= {OW{1'b0}};
      stack_q         <= {OW{1'b0}};
      rated_q         <= {LW{1'b0}};
      limit_q         <= `MSP_LIMIT_RST;
      policy_q        <= 8'h00;
      slot_q          <= {SLW{1'b0}};
      safety_q        <= 1'b0;
      card_req_q      <= 1'b0;
      valid_q         <= 1'b0;
      SWAP_FAULT      <= 1'b0;
      START_OK        <= 1'b0;
      CARD_COPY_BUSY  <= 1'b0;
      SWAP_CLASS      <= `MSP_CLS_NONE;
    end else begin
      if (wr_hit(REG_ADDR, `MSP_REG_POLICY, REG_WR)) begin
        policy_q <= REG_WDATA[7:0];
      end
      if (wr_hit(REG_ADDR, `MSP_REG_LIMIT, REG_WR)) begin
        limit_q <= REG_WDATA[LW-1:0];
      end
      if (wr_hit(REG_ADDR, `MSP_REG_SLOT, REG_WR)) begin
        slot_q     <= REG_WDATA[SLW-1:0];
        safety_q   <= REG_WDATA[`MSP_SLOT_SAFE_BIT];
        card_req_q <= REG_WDATA[`MSP_SLOT_CREQ_BIT];
      end
      case (state_q)
        ST_IDLE: begin
          if (runup_go) begin
            START_OK    <= 1'b0;
            SWAP_FAULT  <= 1'b0;
            card_used_q <= 1'b0;
            card_slot_bad_q <= 1'b0;
            state_q     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (link_s && supply_s) begin       // see RULE_19
            if (cls == `MSP_CLS_BOARD && card_ok_s) begin   // see RULE_14
              CARD_COPY_BUSY <= 1'b1;
              copy_cnt_q     <= 16'h0000;
              state_q        <= ST_COPY;
            end else begin
              state_q <= ST_EVAL;
            end
          end
        end
        ST_COPY: begin
          if (copy_cnt_q == COPY - 1) begin
            // card overwrites stored set, even for a foreign slot, see RULE_16
            policy_q        <= CARD_POLICY;
            slot_q          <= CARD_SLOT;
            safety_q        <= CARD_SAFETY;
            card_req_q      <= CARD_REQUIRED;
            limit_q         <= CARD_LIMIT;    // see RULE_18
            card_used_q     <= 1'b1;
            card_slot_bad_q <= (CARD_SLOT != ctrl_slot_s);
            CARD_COPY_BUSY  <= 1'b0;
            state_q         <= ST_EVAL;
          end else begin
            copy_cnt_q <= copy_cnt_q + 16'h0001;
          end
        end
        ST_EVAL: begin
          SWAP_CLASS <= cls;
          // limit lowering ignores the policy outcome, see RULE_11 see RULE_12 see RULE_13
          if (lower_now) begin
            limit_q <= MODULE_LIMIT;
          end
          if (reject_now) begin
            SWAP_FAULT <= 1'b1;               // see RULE_09
          end else begin
            serial_q <= MODULE_SERIAL;        // see RULE_06
            order_q  <= MODULE_ORDER;
            stack_q  <= MODULE_STACK;
            rated_q  <= MODULE_LIMIT;
            valid_q  <= 1'b1;
          end
          state_q <= ST_START;
        end
        ST_START: begin
          START_OK <= start_ok && !SWAP_FAULT;
          state_q  <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // events and interrupt
  always @* begin
    ev = {`MSP_NEV{1'b0}};
    ev[`MSP_EV_DONE]      = (state_q == ST_START);
    ev[`MSP_EV_FAULT]     = (state_q == ST_EVAL) && reject_now;
    ev[`MSP_EV_LIMIT]     = (state_q == ST_EVAL) && lower_now;
    ev[`MSP_EV_START_ERR] = (state_q == ST_START) && !(start_ok && !SWAP_FAULT);
  end

  wire rd_status = REG_RD && (REG_ADDR == `MSP_REG_STATUS);
  wire [`MSP_NEV-1:0] status_d = (rd_status ? {`MSP_NEV{1'b0}} : status_q) | ev;
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= {`MSP_NEV{1'b0}};
      mask_q   <= {`MSP_NEV{1'b0}};
      IRQ      <= 1'b0;
    end else begin
      // a set in the clearing cycle wins
      status_q <= status_d;
      if (wr_hit(REG_ADDR, `MSP_REG_MASK, REG_WR)) begin
        mask_q <= REG_WDATA[`MSP_NEV-1:0];
      end
      IRQ <= |(status_d & mask_q);
    end
  end

  // ==========================================================
  // register read
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (REG_ADDR)
      `MSP_REG_STATUS: rd_d[`MSP_NEV-1:0] = status_q;
      `MSP_REG_MASK:   rd_d[`MSP_NEV-1:0] = mask_q;
      `MSP_REG_POLICY: rd_d[7:0] = policy_q;
      `MSP_REG_LIMIT:  rd_d[LW-1:0] = limit_q;
      `MSP_REG_SERIAL: rd_d[SW-1:0] = serial_q;
      `MSP_REG_RESULT: rd_d[7:0] = {card_slot_bad_q, card_used_q, valid_q, START_OK,
                                    SWAP_FAULT, CARD_COPY_BUSY, SWAP_CLASS};
      `MSP_REG_SLOT:   rd_d[SLW+1:0] = {card_req_q, safety_q, slot_q};
      `MSP_REG_CTRL:   rd_d[LW-1:0] = rated_q;
      default:         rd_d = 32'h0000_0000;
    endcase
  end
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= REG_RD ? rd_d : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// >>> test/msp_far_model.sv
// model of the attached power module and parameter card
`timescale 1ns/1ps
`default_nettype none
module msp_far_model (
  input  wire logic [1:0]  sel,
  input  wire logic        link,
  input  wire logic        card,
  input  wire logic        creq,
  input  wire logic [7:0]  cpol,
  input  wire logic [7:0]  cslot,
  output logic      [31:0] MODULE_SERIAL,
  output logic      [15:0] MODULE_ORDER,
  output logic      [15:0] MODULE_STACK,
  output logic      [15:0] MODULE_LIMIT,
  output logic             MODULE_LINK,
  output logic             CARD_PRESENT,
  output logic             CARD_READABLE,
  output logic      [15:0] CARD_LIMIT,
  output logic      [7:0]  CARD_SLOT,
  output logic             CARD_SAFETY,
  output logic             CARD_REQUIRED,
  output logic      [7:0]  CARD_POLICY
);
  // modules 0,1 share order; 2,3 share order; 0..2 share stack
  assign MODULE_SERIAL = {30'h179a_b034, sel};
  assign MODULE_ORDER  = sel[1] ? 16'hb002 : 16'ha001;
  assign MODULE_STACK  = (sel == 2'h3) ? 16'h0e02 : 16'h0e01;
  assign MODULE_LIMIT  = sel[1] ? (sel[0] ? 16'h0600 : 16'h0c00) : (sel[0] ? 16'h0400 : 16'h0800);
  assign MODULE_LINK   = link;
  assign CARD_PRESENT  = card;
  assign CARD_READABLE = card;
  // absent card: data lines show the inverted pattern
  assign CARD_LIMIT    = {16{~card}} ^ 16'h0300;
  assign CARD_SLOT     = {8{~card}} ^ cslot;
  assign CARD_SAFETY   = ~card;
  assign CARD_REQUIRED = ~card ^ creq;
  assign CARD_POLICY   = {8{~card}} ^ cpol;
endmodule
`default_nettype wire

// >>> test/msp_swap_check_monitor.sv
// port checker for the swap check block
`timescale 1ns/1ps
`default_nettype none
module msp_swap_check_mon #(
  parameter COPY = 4
) (
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        RUNUP_REQ,
  input wire logic        MODULE_LINK,
  input wire logic        SUPPLY_OK,
  input wire logic        CARD_PRESENT,
  input wire logic        CARD_READABLE,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        SWAP_FAULT,
  input wire logic        START_OK,
  input wire logic        CARD_COPY_BUSY,
  input wire logic [1:0]  SWAP_CLASS
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ==========================================
  // copy length counter
  logic [15:0] busy_q;
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) busy_q <= 16'h0;
    else busy_q <= CARD_COPY_BUSY ? busy_q + 16'h1 : 16'h0;
  end
  // ==========================================
  // properties
  property p_fault_cls; SWAP_FAULT |-> SWAP_CLASS != 2'h0; endproperty
  a_fault_cls: assert property (p_fault_cls) else $error("fault without swap");
  property p_start_nf; START_OK |-> !SWAP_FAULT; endproperty
  a_start_nf: assert property (p_start_nf) else $error("start with fault");
  property p_copy_card; CARD_COPY_BUSY |-> CARD_PRESENT && CARD_READABLE; endproperty
  a_copy_card: assert property (p_copy_card) else $error("copy without card");
  property p_copy_sup; CARD_COPY_BUSY |-> MODULE_LINK && SUPPLY_OK; endproperty
  a_copy_sup: assert property (p_copy_sup) else $error("copy without supply");
  property p_copy_len; $fell(CARD_COPY_BUSY) |-> busy_q == COPY; endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy length wrong");
  property p_busy_quiet; CARD_COPY_BUSY |-> !START_OK && !SWAP_FAULT; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("result during copy");
  property p_rd_zero; !REG_RD |=> REG_RDATA == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data without read");
  property p_start_fall;
    $fell(START_OK) |-> $past(RUNUP_REQ, 2) || $past(RUNUP_REQ, 3) || $past(RUNUP_REQ, 4);
  endproperty
  a_start_fall: assert property (p_start_fall) else $error("start dropped unasked");
endmodule
`default_nettype wire

// >>> test/tb_msp_swap_check.sv
// self-checking bench for the module swap policy check block
`timescale 1ns/1ps
`default_nettype none
module tb_msp_swap_check;
  logic        SYS_CLK, NRST, RUNUP_REQ, BOARD_NEW, BOARD_WAS_OFF, SUPPLY_OK, REG_WR, REG_RD;
  logic        CTRL_SAFETY, CTRL_CARD_REQ, link, card, creq;
  logic [1:0]  sel;
  logic [3:0]  REG_ADDR, msk;
  logic [7:0]  CTRL_SLOT, cpol, cslot;
  logic [31:0] REG_WDATA, eser;
  wire         MODULE_LINK, CARD_PRESENT, CARD_READABLE, CARD_SAFETY, CARD_REQUIRED;
  wire  [31:0] MODULE_SERIAL, REG_RDATA;
  wire  [15:0] MODULE_ORDER, MODULE_STACK, MODULE_LIMIT, CARD_LIMIT;
  wire  [7:0]  CARD_SLOT, CARD_POLICY;
  wire         IRQ, SWAP_FAULT, START_OK, CARD_COPY_BUSY;
  wire  [1:0]  SWAP_CLASS;
  int          miscompares, total_checks;
  msp_far_model far (.sel, .link, .card, .creq, .cpol, .cslot, .MODULE_SERIAL, .MODULE_ORDER,
    .MODULE_STACK, .MODULE_LIMIT, .MODULE_LINK, .CARD_PRESENT, .CARD_READABLE, .CARD_LIMIT,
    .CARD_SLOT, .CARD_SAFETY, .CARD_REQUIRED, .CARD_POLICY);
  msp_swap_check #(.COPY(4)) uut (.SYS_CLK, .NRST, .RUNUP_REQ, .BOARD_NEW, .BOARD_WAS_OFF,
    .MODULE_LINK, .SUPPLY_OK, .MODULE_SERIAL, .MODULE_ORDER, .MODULE_STACK, .MODULE_LIMIT,
    .CARD_PRESENT, .CARD_READABLE, .CARD_LIMIT, .CARD_SLOT, .CARD_SAFETY, .CARD_REQUIRED,
    .CARD_POLICY, .CTRL_SLOT, .CTRL_SAFETY, .CTRL_CARD_REQ, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .IRQ, .SWAP_FAULT, .START_OK, .CARD_COPY_BUSY, .SWAP_CLASS);
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(posedge SYS_CLK);
    d = REG_RDATA;
  endtask
  // one run-up: f is {new board, board was off, card}
  task automatic run(input logic [7:0] pol, input logic [1:0] s, input logic [2:0] f,
                     input logic [3:0] est, input logic [1:0] ecl, input logic lag);
    logic [31:0] d;
    wr(4'h2, {24'h0, pol});
    @(posedge SYS_CLK);
    sel <= s;
    {BOARD_NEW, BOARD_WAS_OFF, card} <= f;
    RUNUP_REQ <= 1'b1;
    if (lag) begin
      repeat (12) @(posedge SYS_CLK);
      chk("busy_no_link", CARD_COPY_BUSY, 1'b0);
      link <= 1'b1;
      repeat (12) @(posedge SYS_CLK);
      chk("busy_no_supply", CARD_COPY_BUSY, 1'b0);
      SUPPLY_OK <= 1'b1;
    end
    for (int i = 0; i < 80 && IRQ !== 1'b1; i++) @(posedge SYS_CLK);
    RUNUP_REQ <= 1'b0;
    #1;
    chk("irq", IRQ, |(est & msk));
    rd(4'h0, d);
    chk("status", d, est);
    chk("class", SWAP_CLASS, ecl);
    chk("fault", SWAP_FAULT, est[1]);
    chk("start", START_OK, !est[3]);
    if (!est[1] && ecl != 2'h0) eser = {30'h179a_b034, s};
    rd(4'h4, d);
    chk("serial", d, eser);
    chk("irq_clear", IRQ, 1'b0);
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    rd(4'h3, d);
    chk("limit_rst", d, 32'hffff);
    rd(4'h2, d);
    chk("policy_rst", d, 32'h0);
    wr(4'h9, 32'hff);
    rd(4'h9, d);
    chk("unmapped", d, 32'h0);
    wr(4'h1, 32'hf);
    rd(4'h1, d);
    chk("mask", d, 32'hf);
  endtask
  task automatic t_first;
    logic [31:0] d;
    run(8'h30, 2'h0, 3'h0, 4'h5, 2'h2, 1'b0);
    rd(4'h3, d);
    chk("limit_low", d, 32'h800);
    wr(4'h1, 32'h2);
    msk = 4'h2;
    run(8'h30, 2'h0, 3'h0, 4'h1, 2'h0, 1'b0);
    wr(4'h1, 32'hf);
    msk = 4'hf;
  endtask
  task automatic t_power;
    logic [15:0] tab [6] = '{16'h301f, 16'h312b, 16'h323b, 16'h3111, 16'h3221, 16'h3331};
    logic [31:0] d;
    foreach (tab[i]) run(tab[i][15:8], tab[i][5:4], 3'h0, tab[i][3:0], 2'h1, 1'b0);
    rd(4'h3, d);
    chk("limit_kept", d, 32'h400);
    rd(4'h7, d);
    chk("rated", d, 32'h600);
  endtask
  task automatic t_board;
    logic [15:0] tab [4] = '{16'h032b, 16'h1321, 16'h233b, 16'h3331};
    foreach (tab[i]) run(tab[i][15:8], tab[i][5:4], 3'h2, tab[i][3:0], 2'h2, 1'b0);
    run(8'h33, 2'h3, 3'h4, 4'h1, 2'h2, 1'b0);
  endtask
  task automatic t_card;
    logic [31:0] d;
    @(posedge SYS_CLK);
    CTRL_SLOT <= 8'h5a;
    run(8'h33, 2'h3, 3'h0, 4'h9, 2'h0, 1'b0);
    cslot <= 8'h11;
    cpol <= 8'h33;
    run(8'h33, 2'h3, 3'h5, 4'h9, 2'h2, 1'b0);
    rd(4'h6, d);
    chk("slot_loaded", d[7:0], 8'h11);
    rd(4'h5, d);
    chk("result", d, 32'he2);
    cslot <= 8'h5a;
    cpol <= 8'h03;
    run(8'h33, 2'h3, 3'h5, 4'hb, 2'h2, 1'b0);
    {cpol, creq, CTRL_CARD_REQ, link, SUPPLY_OK} <= 12'h33c;
    run(8'h00, 2'h2, 3'h5, 4'h1, 2'h2, 1'b1);
    rd(4'h3, d);
    chk("card_limit", d, 32'h300);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    {NRST, RUNUP_REQ, BOARD_NEW, BOARD_WAS_OFF, REG_WR, REG_RD, CTRL_SAFETY, CTRL_CARD_REQ} = '0;
    {card, creq, sel, REG_ADDR, CTRL_SLOT, cpol, cslot, REG_WDATA} = '0;
    {SUPPLY_OK, link, msk} = 6'h3f;
    repeat (6) @(posedge SYS_CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    t_regs;
    t_first;
    t_power;
    t_board;
    t_card;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares++;
    tally_and_finish;
  end
endmodule
bind msp_swap_check msp_swap_check_mon #(.COPY(COPY)) u_mon (.SYS_CLK, .NRST, .RUNUP_REQ,
  .MODULE_LINK, .SUPPLY_OK, .CARD_PRESENT, .CARD_READABLE, .REG_RD, .REG_RDATA, .SWAP_FAULT,
  .START_OK, .CARD_COPY_BUSY, .SWAP_CLASS);
`default_nettype wire
